// file: core/sdb_pkg.sv
// Package with register map, field layout and timing constants of the stall and brake energy block
// How it works
// RL1: Braking transistor energy is summed and readable as a kWh total.
// RL2: Energy per tick uses the configured braking resistance value.
// RL3: Energy total saturates at its maximum instead of wrapping.
// RL4: Total is writable; reinit or hour-counter write restores its default.
// RL5: Stall check compares ramp output speed with actual speed.
// RL6: Armed only while set value and ramp speed exceed the level.
// RL7: Armed and slow actual speed counts up to wait time, then blockade.
// RL8: Reaction mode zero disables stall detection.
// RL9: Mode one freezes control state until set value reaches zero.
// RL10: Mode two ramps active current and speed to zero over ramp time.
// RL11: Mode three zeroes output frequency, then ramps currents over ramp time.
// RL12: Select bit picks zero or rated magnetizing current as ramp target.
// RL13: Select bit clear gives warning output, cleared by zero or sign change.
// RL14: Select bit set gives latched blockade error, excluded from auto reset.
// RL15: After the ramp time the chosen warning or error reaction follows.
// RL16: Current scale falls monotonically to zero at end of ramp time.
// RL17: Mode field is bits 0 to 2; values 4 to 7 mean no reaction.
package sdb_pkg;
    localparam logic [7:0] ADDR_RESISTANCE = 8'h00;
    localparam logic [7:0] ADDR_ENERGY = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_LEVEL = 8'h0C;
    localparam logic [7:0] ADDR_WAIT = 8'h10;
    localparam logic [7:0] ADDR_RAMP = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
    localparam logic [7:0] ADDR_CTRL = 8'h24;
    localparam int MODE_LSB = 0;
    localparam int MAG_SEL_BIT = 3;
    localparam int ERR_SEL_BIT = 4;
    localparam int CTRL_REINIT_BIT = 0;
    localparam int CTRL_HOURWR_BIT = 1;
    localparam int CTRL_ERRRST_BIT = 2;
    localparam logic [31:0] ENERGY_MAX = 32'h0001_869F;
    localparam logic [31:0] ENERGY_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] RESIST_DEFAULT = 32'h0000_0000;
    localparam logic [7:0] MODE_DEFAULT = 8'h00;
    localparam logic [31:0] LEVEL_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] TIME_DEFAULT = 32'h0000_0000;
    localparam logic [2:0] BLOCKADE_ERROR_CODE = 3'h0;
    localparam logic [7:0] ERROR_CODE_BLOCKADE = 8'h1D;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_US = 10000;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int IRQ_BITS = 3;
    typedef enum logic [2:0] {
        RM_OFF,
        RM_FREEZE,
        RM_RAMP_SLIP,
        RM_RAMP_DC,
        RM_RES4,
        RM_RES5,
        RM_RES6,
        RM_RES7
    } sdb_mode_e;
    typedef struct packed {
        logic modOff;
        logic freeze;
        logic freqZero;
        logic magRated;
        logic [15:0] currentScale;
    } sdb_drive_s;
endpackage

// file: core/sdb_ramp.sv
// Linear down-ramp of the current scale over a programmable number of ticks
`timescale 1ns/10ps
`default_nettype none
module sdb_ramp #(
    parameter int SCALE_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic tick,
    input wire logic [31:0] rampTicks,
    // Result
    output logic [SCALE_W-1:0] scale,
    output logic done
);
    initial
    begin
        if (SCALE_W < 2 || SCALE_W > 31)
        begin
            $error("SCALE_W out of range");
        end
    end

    logic [31:0] elapsed;
    logic running;
    logic [47:0] prod;

    // Scale = full * (1 - elapsed/ramp), never rising during a ramp
    always_comb
    begin
        prod = 48'(elapsed) << SCALE_W;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            elapsed <= 32'h0000_0000;
            running <= 1'b0;
            done <= 1'b0;
            scale <= '1;
        end
        else if (start)
        begin
            elapsed <= 32'h0000_0000;
            running <= (rampTicks != 32'h0000_0000);
            done <= (rampTicks == 32'h0000_0000);
            scale <= (rampTicks == 32'h0000_0000) ? '0 : '1;
        end
        else if (running && tick)
        begin
            // Division done once per tick; slow ticks leave time for it
            elapsed <= elapsed + 32'h0000_0001;
            if (elapsed + 32'h0000_0001 >= rampTicks)
            begin
                running <= 1'b0;
                done <= 1'b1;
                scale <= '0; // RL16
            end
            else
            begin
                scale <= SCALE_W'({1'b0, {SCALE_W{1'b1}}} - SCALE_W'(((prod + 48'(SCALE_W'(elapsed))) / 48'(rampTicks))));
            end
        end
    end

    a_ramp_monotonic: assert property (@(posedge mclk) disable iff (!rst_n)
        (running && !start) |=> (scale <= $past(scale))) else $error("ramp scale rose"); // RL16
    a_ramp_ends_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(done) |-> (scale == '0)) else $error("ramp not zero at end"); // RL16
endmodule
`default_nettype wire

// file: core/sdb_core.sv
// Stall detection with blockade reactions and braking energy accumulator, Wishbone slave
`timescale 1ns/10ps
`default_nettype none
module sdb_core #(
    parameter int TICK_CYCLES = sdb_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Drive signals, same clock
    input wire logic signed [31:0] setValue,
    input wire logic signed [31:0] rampOutputSpeed,
    input wire logic signed [31:0] actualSpeed,
    input wire logic [31:0] brakeVoltSq,
    input wire logic brakeTransistorPin,
    // Reactions
    output sdb_pkg::sdb_drive_s drive,
    output logic warnOut,
    output logic blockadeError,
    output logic [7:0] errorCode,
    output logic irq
);
    initial
    begin
        if (TICK_CYCLES < 1)
        begin
            $error("TICK_CYCLES must be at least 1");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_FREEZE,
        ST_RAMP,
        ST_REACT
    } sdb_state_e;

    logic [31:0] resistance;
    logic [31:0] energyTotal;
    logic [7:0] modeReg;
    logic [31:0] levelReg;
    logic [31:0] waitReg;
    logic [31:0] rampReg;
    logic [2:0] irqStatus;
    logic [2:0] irqEnable;
    sdb_state_e state;
    logic [31:0] tickCnt;
    logic tick;
    logic [31:0] stallCnt;
    logic [31:0] energyFrac;
    logic [2:0] brakeSync;
    logic brakeOn;
    logic rampStart;
    logic rampDone;
    logic [15:0] rampScale;
    logic busWrite;
    logic busRead;
    logic reinit;
    logic hourWrite;
    logic errReset;
    logic armed;
    logic slowNow;
    logic blockade;
    logic setSign;
    logic [31:0] next_frac;
    logic [31:0] powerPerTick;
    sdb_pkg::sdb_mode_e mode;

    // Single-cycle classic access; ack drops after one cycle
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign reinit = busWrite && wb_adr_i == sdb_pkg::ADDR_CTRL && wb_sel_i[0] && wb_dat_i[sdb_pkg::CTRL_REINIT_BIT];
    assign hourWrite = busWrite && wb_adr_i == sdb_pkg::ADDR_CTRL && wb_sel_i[0] && wb_dat_i[sdb_pkg::CTRL_HOURWR_BIT];
    assign errReset = busWrite && wb_adr_i == sdb_pkg::ADDR_CTRL && wb_sel_i[0] && wb_dat_i[sdb_pkg::CTRL_ERRRST_BIT];
    assign mode = sdb_pkg::sdb_mode_e'(modeReg[sdb_pkg::MODE_LSB +: 3]);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Configuration registers
    always_ff @(posedge mclk)
    begin
        if (!rst_n || reinit)
        begin
            resistance <= sdb_pkg::RESIST_DEFAULT;
            modeReg <= sdb_pkg::MODE_DEFAULT;
            levelReg <= sdb_pkg::LEVEL_DEFAULT;
            waitReg <= sdb_pkg::TIME_DEFAULT;
            rampReg <= sdb_pkg::TIME_DEFAULT;
            irqEnable <= 3'h0;
        end
        else if (busWrite)
        begin
            case (wb_adr_i)
                sdb_pkg::ADDR_RESISTANCE: resistance <= merge(resistance, wb_dat_i, wb_sel_i);
                sdb_pkg::ADDR_MODE: modeReg <= wb_sel_i[0] ? wb_dat_i[7:0] : modeReg;
                sdb_pkg::ADDR_LEVEL: levelReg <= merge(levelReg, wb_dat_i, wb_sel_i);
                sdb_pkg::ADDR_WAIT: waitReg <= merge(waitReg, wb_dat_i, wb_sel_i);
                sdb_pkg::ADDR_RAMP: rampReg <= merge(rampReg, wb_dat_i, wb_sel_i);
                sdb_pkg::ADDR_IRQ_EN: irqEnable <= wb_sel_i[0] ? wb_dat_i[2:0] : irqEnable;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (busRead)
        begin
            case (wb_adr_i)
                sdb_pkg::ADDR_RESISTANCE: wb_dat_o <= resistance;
                sdb_pkg::ADDR_ENERGY: wb_dat_o <= energyTotal; // RL1
                sdb_pkg::ADDR_MODE: wb_dat_o <= {24'h00_0000, modeReg};
                sdb_pkg::ADDR_LEVEL: wb_dat_o <= levelReg;
                sdb_pkg::ADDR_WAIT: wb_dat_o <= waitReg;
                sdb_pkg::ADDR_RAMP: wb_dat_o <= rampReg;
                sdb_pkg::ADDR_STATUS: wb_dat_o <= {24'h00_0000, warnOut, blockadeError, 3'(state), irqStatus};
                sdb_pkg::ADDR_IRQ_EN: wb_dat_o <= {29'h0000_0000, irqEnable};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Timebase tick for counters and ramps
    always_ff @(posedge mclk)
    begin
        if (!rst_n || tickCnt == 32'(TICK_CYCLES - 1))
        begin
            tickCnt <= 32'h0000_0000;
        end
        else
        begin
            tickCnt <= tickCnt + 32'h0000_0001;
        end
    end
    assign tick = rst_n && tickCnt == 32'(TICK_CYCLES - 1);

    // Transistor gate pin synchroniser, second and third stages must agree
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            brakeSync <= 3'h0;
            brakeOn <= 1'b0;
        end
        else
        begin
            brakeSync <= {brakeSync[1:0], brakeTransistorPin};
            if (brakeSync[1] == brakeSync[2])
            begin
                brakeOn <= brakeSync[2];
            end
        end
    end

    // Power = U^2/R per tick; unset resistance adds nothing, so the total is wrong until set
    assign powerPerTick = (resistance == 32'h0000_0000) ? 32'h0000_0000 : brakeVoltSq / resistance; // RL2
    assign next_frac = energyFrac + powerPerTick;

    // Energy accumulator in kWh with fractional remainder
    always_ff @(posedge mclk)
    begin
        if (!rst_n || reinit || hourWrite)
        begin
            energyTotal <= sdb_pkg::ENERGY_DEFAULT; // RL4
            energyFrac <= 32'h0000_0000;
        end
        else if (busWrite && wb_adr_i == sdb_pkg::ADDR_ENERGY)
        begin
            energyTotal <= merge(energyTotal, wb_dat_i, wb_sel_i) > sdb_pkg::ENERGY_MAX ? sdb_pkg::ENERGY_MAX
                : merge(energyTotal, wb_dat_i, wb_sel_i); // RL4
        end
        else if (tick && brakeOn)
        begin
            energyFrac <= next_frac % 32'h0010_0000;
            if (energyTotal + (next_frac >> 20) >= sdb_pkg::ENERGY_MAX)
            begin
                energyTotal <= sdb_pkg::ENERGY_MAX; // RL3
            end
            else
            begin
                energyTotal <= energyTotal + (next_frac >> 20); // RL1
            end
        end
    end

    // Arming and slow-speed detection on magnitudes
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction
    assign armed = mag(setValue) > levelReg && mag(rampOutputSpeed) > levelReg; // RL6
    assign slowNow = mag(actualSpeed) < levelReg; // RL5
    assign blockade = state == ST_WAIT && tick && stallCnt + 32'h0000_0001 >= waitReg;

    // Stall timer, restarts whenever arming or slow speed drops
    always_ff @(posedge mclk)
    begin
        if (!rst_n || state != ST_WAIT || !armed || !slowNow)
        begin
            stallCnt <= 32'h0000_0000;
        end
        else if (tick)
        begin
            stallCnt <= stallCnt + 32'h0000_0001; // RL7
        end
    end

    // Reaction sequencer
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            setSign <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (mode inside {sdb_pkg::RM_FREEZE, sdb_pkg::RM_RAMP_SLIP, sdb_pkg::RM_RAMP_DC}) // RL8 RL17
                    begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    setSign <= setValue[31];
                    if (!(mode inside {sdb_pkg::RM_FREEZE, sdb_pkg::RM_RAMP_SLIP, sdb_pkg::RM_RAMP_DC}))
                    begin
                        state <= ST_IDLE; // RL8 RL17
                    end
                    else if (blockade && armed && slowNow)
                    begin
                        state <= (mode == sdb_pkg::RM_FREEZE) ? ST_FREEZE : ST_RAMP; // RL7
                    end
                end
                ST_FREEZE:
                begin
                    if (setValue == 32'sh0000_0000)
                    begin
                        state <= ST_REACT; // RL9
                    end
                end
                ST_RAMP:
                begin
                    if (rampDone && !rampStart)
                    begin
                        state <= ST_REACT; // RL15
                    end
                end
                ST_REACT:
                begin
                    // Warning ends on zero or sign change; error waits for manual reset
                    if (!modeReg[sdb_pkg::ERR_SEL_BIT] && (setValue == 32'sh0000_0000 || setValue[31] != setSign))
                    begin
                        state <= ST_IDLE; // RL13
                    end
                    else if (modeReg[sdb_pkg::ERR_SEL_BIT] && errReset)
                    begin
                        state <= ST_IDLE; // RL14
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign rampStart = blockade && armed && slowNow && mode inside {sdb_pkg::RM_RAMP_SLIP, sdb_pkg::RM_RAMP_DC};

    sdb_ramp #(
        .SCALE_W(16)
    ) u_ramp (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(rampStart),
        .tick(tick),
        .rampTicks(rampReg),
        .scale(rampScale),
        .done(rampDone)
    );

    // Drive outputs; current stays at zero after a ramp until the reaction ends, error latches modulation off
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            drive <= '0;
            warnOut <= 1'b0;
            blockadeError <= 1'b0;
            errorCode <= 8'h00;
        end
        else
        begin
            drive.freeze <= state == ST_FREEZE; // RL9
            drive.freqZero <= state == ST_RAMP && mode == sdb_pkg::RM_RAMP_DC; // RL11
            drive.magRated <= modeReg[sdb_pkg::MAG_SEL_BIT]; // RL12
            drive.currentScale <= (state == ST_RAMP || (state == ST_REACT && mode inside {sdb_pkg::RM_RAMP_SLIP,
                sdb_pkg::RM_RAMP_DC})) ? rampScale : 16'hFFFF; // RL10 RL16
            drive.modOff <= state == ST_REACT && modeReg[sdb_pkg::ERR_SEL_BIT]; // RL14
            warnOut <= state == ST_REACT && !modeReg[sdb_pkg::ERR_SEL_BIT]; // RL13
            blockadeError <= state == ST_REACT && modeReg[sdb_pkg::ERR_SEL_BIT]; // RL14
            errorCode <= (state == ST_REACT && modeReg[sdb_pkg::ERR_SEL_BIT]) ? sdb_pkg::ERROR_CODE_BLOCKADE : 8'h00;
        end
    end

    // Sticky events: trigger, warning, error; set wins over clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irqStatus <= 3'h0;
        end
        else
        begin
            irqStatus <= (irqStatus & ~((busWrite && wb_adr_i == sdb_pkg::ADDR_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[2:0]
                : 3'h0)) | {state == ST_REACT && modeReg[sdb_pkg::ERR_SEL_BIT] && !blockadeError,
                state == ST_REACT && !modeReg[sdb_pkg::ERR_SEL_BIT] && !warnOut, blockade && armed && slowNow};
        end
    end
    assign irq = |(irqStatus & irqEnable);

    a_energy_saturates: assert property (@(posedge mclk) disable iff (!rst_n)
        energyTotal <= sdb_pkg::ENERGY_MAX) else $error("energy total above maximum"); // RL3
    a_energy_hour_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        hourWrite |=> energyTotal == sdb_pkg::ENERGY_DEFAULT) else $error("hour write kept energy"); // RL4
    a_off_no_trigger: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == sdb_pkg::RM_OFF) |-> !rampStart && state != ST_FREEZE) else $error("trigger while off"); // RL8
    a_stall_needs_arm: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_WAIT && !armed) |=> stallCnt == 32'h0000_0000) else $error("timer ran unarmed"); // RL6
    a_freeze_shown: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_FREEZE) |=> drive.freeze) else $error("freeze not driven"); // RL9
    a_error_mod_off: assert property (@(posedge mclk) disable iff (!rst_n)
        blockadeError |-> drive.modOff && errorCode == sdb_pkg::ERROR_CODE_BLOCKADE) else $error("error without off"); // RL14
    a_error_no_warn: assert property (@(posedge mclk) disable iff (!rst_n)
        !(warnOut && blockadeError)) else $error("warning and error together"); // RL13
    a_dc_freq_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_RAMP && mode == sdb_pkg::RM_RAMP_DC) |=> drive.freqZero) else $error("frequency not zeroed"); // RL11
    a_ramp_then_react: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_RAMP && rampDone && !rampStart) |=> state == ST_REACT) else $error("no reaction after ramp"); // RL15
endmodule
`default_nettype wire

// file: test/sdb_core_tb.sv
// Register-level bench for the stall detection and brake energy block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin errTotal++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb;
    localparam int TICK = 8;
    logic mclk;
    logic rst_n;
    logic wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rdq, voltSq;
    logic signed [31:0] setValue, rampSpeed, actSpeed;
    logic brakePin, warnOut, blockadeError, irq;
    logic [7:0] errorCode;
    sdb_pkg::sdb_drive_s drive;
    int errTotal;
    int checksDone;
    logic [7:0] ntMode [4] = '{8'h10, 8'h15, 8'h12, 8'h12};
    int ntSet [4] = '{100, 100, 100, 5};
    int ntAct [4] = '{0, 0, 50, 0};
    sdb_core #(.TICK_CYCLES(TICK)) i_sdb_core (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .setValue(setValue), .rampOutputSpeed(rampSpeed), .actualSpeed(actSpeed),
        .brakeVoltSq(voltSq), .brakeTransistorPin(brakePin), .drive(drive), .warnOut(warnOut),
        .blockadeError(blockadeError), .errorCode(errorCode), .irq(irq));
    // Short tick keeps every stall count within a few hundred cycles
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One classic cycle; request held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatW <= d;
        wbSel <= 4'hF;
        @(posedge mclk);
        while (wbAck !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
            `CHK("bus ack", 1'b1, wbAck)
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0000_0000, rdq);
    endtask
    task automatic speeds(input int s, input int r, input int a);
        @(posedge mclk);
        setValue <= s;
        rampSpeed <= r;
        actSpeed <= a;
    endtask
    // Polls one status bit under a bounded count, then lets outputs settle
    task automatic poll(input int b, input logic v, input string nm);
        logic [31:0] q;
        int n;
        n = 0;
        q = {32{~v}};
        while (q[b] !== v && n < 60)
        begin
            xfer(1'b0, sdb_pkg::ADDR_STATUS, 32'h0000_0000, q);
            n++;
        end
        `CHK(nm, v, q[b])
        repeat (2) @(posedge mclk);
    endtask
    // Returns the reaction to idle so the next test starts clean
    task automatic cleanup;
        speeds(0, 0, 0);
        wr(sdb_pkg::ADDR_CTRL, 32'h0000_0004);
        wr(sdb_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
    endtask
    // Hang guard, well beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (30000) @(posedge mclk);
        errTotal++;
        printVerdict();
    end
    initial
    begin
        errTotal = 0;
        checksDone = 0;
        rst_n = 1'b0;
        {wbCyc, wbStb, wbWe, brakePin} = 4'h0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h0000_0000;
        voltSq = 32'h0010_0000;
        {setValue, rampSpeed, actSpeed} = '0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        // Defaults after reset and an unmapped read
        foreach (ntSet[i])
        begin
            rd(8'h04 * i[7:0]);
            `CHK("reg default", 32'h0000_0000, rdq)
        end
        rd(8'h40);
        `CHK("unmapped", 32'h0000_0000, rdq)
        `CHK("scale full", 16'hFFFF, drive.currentScale)
        $display("test reset done");
        // Energy: accumulate, resistance scaling, clamp and saturation, clears
        wr(sdb_pkg::ADDR_RESISTANCE, 32'h0000_0001);
        wr(sdb_pkg::ADDR_ENERGY, 32'h0000_0000);
        brakePin <= 1'b1;
        repeat (10 * TICK) @(posedge mclk);
        brakePin <= 1'b0;
        repeat (TICK) @(posedge mclk);
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("energy r1", 1'b1, rdq >= 8 && rdq <= 11)
        wr(sdb_pkg::ADDR_RESISTANCE, 32'h0000_0004);
        wr(sdb_pkg::ADDR_ENERGY, 32'h0000_0000);
        brakePin <= 1'b1;
        repeat (10 * TICK) @(posedge mclk);
        brakePin <= 1'b0;
        repeat (TICK) @(posedge mclk);
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("energy r4", 1'b1, rdq >= 1 && rdq <= 3)
        wr(sdb_pkg::ADDR_ENERGY, 32'h0003_0D40);
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("energy clamp", sdb_pkg::ENERGY_MAX, rdq)
        wr(sdb_pkg::ADDR_RESISTANCE, 32'h0000_0001);
        wr(sdb_pkg::ADDR_ENERGY, 32'h0001_869E);
        brakePin <= 1'b1;
        repeat (6 * TICK) @(posedge mclk);
        brakePin <= 1'b0;
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("energy sat", sdb_pkg::ENERGY_MAX, rdq)
        wr(sdb_pkg::ADDR_CTRL, 32'h0000_0002);
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("hour clear", sdb_pkg::ENERGY_DEFAULT, rdq)
        wr(sdb_pkg::ADDR_ENERGY, 32'h0000_0007);
        wr(sdb_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(sdb_pkg::ADDR_ENERGY);
        `CHK("reinit clear", sdb_pkg::ENERGY_DEFAULT, rdq)
        $display("test energy done");
        // Stall setup: level 10, wait 2 ticks, ramp 4 ticks
        wr(sdb_pkg::ADDR_LEVEL, 32'h0000_000A);
        wr(sdb_pkg::ADDR_WAIT, 32'h0000_0002);
        wr(sdb_pkg::ADDR_RAMP, 32'h0000_0004);
        // Cases that must never trigger: off, reserved, fast actual, low set
        foreach (ntMode[i])
        begin
            wr(sdb_pkg::ADDR_MODE, {24'h00_0000, ntMode[i]});
            speeds(ntSet[i], ntSet[i], ntAct[i]);
            repeat (6 * TICK) @(posedge mclk);
            rd(sdb_pkg::ADDR_STATUS);
            `CHK("no trigger", 5'h00, {rdq[7:6], rdq[2:0]})
            `CHK("no error", 1'b0, blockadeError)
            cleanup();
        end
        $display("test arming done");
        // Freeze with error selected; irq enable, mask and clear
        wr(sdb_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        wr(sdb_pkg::ADDR_MODE, 32'h0000_0011);
        speeds(100, 100, 0);
        poll(0, 1'b1, "freeze trig");
        `CHK("freeze", 1'b1, drive.freeze)
        `CHK("held no err", 1'b0, blockadeError)
        `CHK("irq on", 1'b1, irq)
        wr(sdb_pkg::ADDR_IRQ_EN, 32'h0000_0000);
        `CHK("irq masked", 1'b0, irq)
        wr(sdb_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        speeds(0, 0, 0);
        poll(6, 1'b1, "freeze err");
        `CHK("err code", sdb_pkg::ERROR_CODE_BLOCKADE, errorCode)
        `CHK("mod off", 1'b1, drive.modOff)
        cleanup();
        `CHK("err reset", 1'b0, blockadeError)
        `CHK("irq cleared", 1'b0, irq)
        $display("test freeze done");
        // Ramp with slip, zero magnetizing, error after the ramp
        wr(sdb_pkg::ADDR_MODE, 32'h0000_0012);
        speeds(100, 100, 0);
        poll(0, 1'b1, "slip trig");
        `CHK("ramping no err", 1'b0, blockadeError)
        `CHK("mag zero", 1'b0, drive.magRated)
        poll(6, 1'b1, "slip err");
        `CHK("scale zero", 16'h0000, drive.currentScale)
        `CHK("mod off", 1'b1, drive.modOff)
        speeds(0, 0, 0);
        repeat (4 * TICK) @(posedge mclk);
        `CHK("no auto reset", 1'b1, blockadeError)
        cleanup();
        $display("test slip done");
        // DC ramp, rated magnetizing, warning cleared by sign change
        wr(sdb_pkg::ADDR_MODE, 32'h0000_000B);
        speeds(100, 100, 0);
        poll(0, 1'b1, "dc trig");
        `CHK("freq zero", 1'b1, drive.freqZero)
        `CHK("mag rated", 1'b1, drive.magRated)
        poll(7, 1'b1, "dc warn");
        `CHK("warn out", 1'b1, warnOut)
        `CHK("warn no err", 1'b0, blockadeError)
        speeds(-100, 100, 0);
        poll(7, 1'b0, "warn clear");
        `CHK("warn off", 1'b0, warnOut)
        cleanup();
        $display("test dc done");
        printVerdict();
    end
endmodule
`default_nettype wire
